/* hw/smr_pkg.sv */
// Constants for the mode register zero burst logic.
// Assumes a 100 MHz core clock that samples the memory clock pin.
package smr_pkg;
	localparam int MR_W = 19;
	localparam int COL_W = 10;
	localparam int DQ_W = 8;
	localparam int BL_LO = 0;
	localparam int BT_BIT = 3;
	localparam int CL_LO = 4;
	localparam int DLL_BIT = 8;
	localparam int WR_LO = 9;
	localparam int PPD_BIT = 12;
	localparam int OTF_BIT = 12;
	localparam logic [MR_W-1:0] MR_RESET = 19'h00000;
	localparam logic [MR_W-1:0] MR_RSVD_MASK = 19'h4e080;
	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_OTF = 2'h1;
	localparam logic [1:0] BL_CHOP4 = 2'h2;
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam logic [2:0] CMD_MODE_SET = 3'h0;
	localparam logic [2:0] CMD_READ = 3'h5;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [3:0] CL_MIN = 4'h5;
	localparam logic [3:0] CL_MAX = 4'ha;
	localparam logic [3:0] BEATS_8 = 4'h8;
	localparam logic [3:0] BEATS_4 = 4'h4;
	localparam int DLL_LOCK_CYC = 512;
	localparam int FIFO_DEPTH = 16;
endpackage : smr_pkg

/* hw/smr_core.sv */
// Burst ordering, latency and mode field decode behind the command pins.
// Assumes the memory clock pin is sampled by i_clk; commands are taken at its rising edge.
`timescale 1ns/100ps
module smr_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [W-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [W-1:0] o_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_q [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;
	// Honest full and empty from one count
	assign o_ready = (cnt_q != (AW+1)'(D));
	assign o_valid = (cnt_q != '0);
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;
	assign o_data = mem_q[rp_q];
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wp_q] <= i_data;
		end
	end
	// Pointers and fill level
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= rp_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : smr_fifo

module smr_core
	import smr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_mem_clk,
	input wire logic [2:0] i_cmd,
	input wire logic [MR_W-1:0] i_addr,
	input wire logic i_power_down,
	input wire logic [DQ_W-1:0] i_wdata,
	input wire logic i_rd_valid,
	output logic o_rd_ready,
	input wire logic [DQ_W-1:0] i_rd_data,
	output logic [DQ_W-1:0] o_dq,
	output logic o_dq_oe,
	output logic o_dqs_oe,
	output logic o_wr_en,
	output logic [COL_W-1:0] o_wr_col,
	output logic [DQ_W-1:0] o_wr_data,
	output logic [COL_W-1:0] o_rd_col,
	output logic o_rd_col_valid,
	output logic o_dll_reset,
	output logic o_dll_run,
	output logic [3:0] o_write_recovery,
	output logic [3:0] o_read_latency,
	output logic [MR_W-1:0] o_mode
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_BURST = 3'b100
	} smr_state_t;
	smr_state_t st_q;
	logic [2:0] ck_sync_q;
	logic [2:0] cmd_q [2];
	logic [MR_W-1:0] addr_q [2];
	logic ck_rise;
	logic [MR_W-1:0] mode_q;
	logic dll_req_q;
	logic [3:0] lat_q;
	logic [3:0] beat_q;
	logic [3:0] len_q;
	logic is_read_q;
	logic seq_q;
	logic [2:0] start_q;
	logic [COL_W-1:0] base_q;
	logic [3:0] cl_dec;
	logic [3:0] wr_dec;
	logic chop_cmd;
	logic [2:0] beat_col;
	logic [2:0] cur_cmd;
	logic [MR_W-1:0] cur_addr;
	logic [3:0] beats_out;
	logic fifo_v;
	logic [DQ_W-1:0] fifo_d;
	logic in_chop_tail;
	// Two flops on the clock, command and address pins before logic reads them
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ck_sync_q <= '0;
			cmd_q[0] <= CMD_NOP;
			cmd_q[1] <= CMD_NOP;
			addr_q[0] <= '0;
			addr_q[1] <= '0;
		end else begin
			ck_sync_q <= {ck_sync_q[1:0], i_mem_clk};
			cmd_q[0] <= i_cmd;
			cmd_q[1] <= cmd_q[0];
			addr_q[0] <= i_addr;
			addr_q[1] <= addr_q[0];
		end
	end
	assign ck_rise = ck_sync_q[1] && !ck_sync_q[2];
	assign cur_cmd = ck_rise ? cmd_q[1] : CMD_NOP;
	assign cur_addr = addr_q[1];
	// Mode field decode; unlisted codes fall to the lowest value, 5
	always_comb begin
		cl_dec = CL_MIN;
		case (mode_q[CL_LO+:3])
			3'h1: cl_dec = 4'h5;
			3'h2: cl_dec = 4'h6;
			3'h3: cl_dec = 4'h7;
			3'h4: cl_dec = 4'h8;
			3'h5: cl_dec = 4'h9;
			3'h6: cl_dec = CL_MAX;
			default: cl_dec = CL_MIN;
		endcase
		wr_dec = 4'h5;
		case (mode_q[WR_LO+:3])
			3'h2: wr_dec = 4'h6;
			3'h3: wr_dec = 4'h7;
			3'h4: wr_dec = 4'h8;
			3'h5: wr_dec = 4'ha;
			3'h6: wr_dec = 4'hc;
			default: wr_dec = 4'h5;
		endcase
	end
	// Length per command; same field for reads and writes
	always_comb begin
		case (mode_q[BL_LO+:2])
			BL_CHOP4: chop_cmd = 1'b1;
			BL_OTF: chop_cmd = !cur_addr[OTF_BIT];
			default: chop_cmd = 1'b0;
		endcase
	end
	// Mode store; reserved bits kept at zero even if sent otherwise
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			mode_q <= MR_RESET;
			dll_req_q <= 1'b0;
		end else begin
			dll_req_q <= 1'b0;
			if (cur_cmd == CMD_MODE_SET && st_q == ST_IDLE) begin
				mode_q <= cur_addr & ~MR_RSVD_MASK;
				dll_req_q <= cur_addr[DLL_BIT];
			end else if (dll_req_q) begin
				mode_q[DLL_BIT] <= 1'b0;
			end
		end
	end
	assign o_dll_reset = dll_req_q;
	// DLL idles only in power-down with slow-exit setting
	assign o_dll_run = !(i_power_down && !mode_q[PPD_BIT]);
	assign o_write_recovery = wr_dec;
	assign o_read_latency = cl_dec;
	assign o_mode = mode_q;
	// Burst sequencer counts memory clock edges
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st_q <= ST_IDLE;
			lat_q <= '0;
			beat_q <= '0;
			len_q <= BEATS_8;
			is_read_q <= 1'b0;
			seq_q <= 1'b1;
			start_q <= '0;
			base_q <= '0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (cur_cmd == CMD_READ || cur_cmd == CMD_WRITE) begin
						is_read_q <= (cur_cmd == CMD_READ);
						len_q <= chop_cmd ? BEATS_4 : BEATS_8;
						seq_q <= !mode_q[BT_BIT];
						base_q <= {cur_addr[COL_W-1:3], 3'h0};
						start_q <= cur_addr[2:0];
						// Latency equal for chop and eight
						lat_q <= (cur_cmd == CMD_READ) ? cl_dec - 4'h1 : 4'h0;
						beat_q <= '0;
						st_q <= (cur_cmd == CMD_READ && cl_dec > 4'h1) ? ST_WAIT : ST_BURST;
					end
				end
				ST_WAIT: begin
					if (ck_rise) begin
						lat_q <= lat_q - 4'h1;
						if (lat_q == 4'h1) begin
							st_q <= ST_BURST;
						end
					end
				end
				ST_BURST: begin
					if (ck_rise) begin
						beat_q <= beat_q + 4'h1;
						if (beat_q == BEATS_8 - 4'h1) begin
							st_q <= ST_IDLE;
						end
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end
	// Column of the current beat
	always_comb begin
		if (!is_read_q) begin
			beat_col = len_q == BEATS_4 ? {start_q[2], beat_q[1:0]}
				: beat_q[2:0];
		end else if (!seq_q) begin
			beat_col = beat_q[2:0] ^ start_q;
		end else begin
			beat_col = {beat_q[2] ^ start_q[2], beat_q[1:0] + start_q[1:0]};
		end
	end
	assign in_chop_tail = (len_q == BEATS_4) && beat_q[2];
	assign beats_out = 4'(st_q == ST_BURST && !in_chop_tail);
	// Read data path; stalls the array source when full
	smr_fifo #(.W(DQ_W), .D(FIFO_DEPTH)) u_fifo (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_valid(i_rd_valid),
		.o_ready(o_rd_ready),
		.i_data(i_rd_data),
		.o_valid(fifo_v),
		.i_ready(ck_rise && is_read_q && beats_out[0]),
		.o_data(fifo_d)
	);
	// Pin drivers; chop tail leaves data and strobe off
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_dq <= '0;
			o_dq_oe <= 1'b0;
			o_dqs_oe <= 1'b0;
			o_wr_en <= 1'b0;
			o_wr_col <= '0;
			o_wr_data <= '0;
			o_rd_col <= '0;
			o_rd_col_valid <= 1'b0;
		end else begin
			o_wr_en <= 1'b0;
			o_rd_col_valid <= 1'b0;
			if (ck_rise) begin
				o_dq_oe <= is_read_q && beats_out[0];
				o_dqs_oe <= is_read_q && beats_out[0];
				o_dq <= fifo_v ? fifo_d : '0;
				if (beats_out[0]) begin
					o_rd_col_valid <= is_read_q;
					o_rd_col <= base_q | COL_W'(beat_col);
					o_wr_en <= !is_read_q;
					o_wr_col <= base_q | COL_W'(beat_col);
					o_wr_data <= i_wdata;
				end
			end
		end
	end
	// Self-clear follows a DLL reset request
	a_dll_selfclear: assert property (@(posedge i_clk) disable iff (i_srst)
		dll_req_q |=> !mode_q[DLL_BIT] || $past(cur_cmd == CMD_MODE_SET))
		else $error("dll reset bit did not clear");
	a_reserved_zero: assert property (@(posedge i_clk) disable iff (i_srst)
		(mode_q & MR_RSVD_MASK) == '0)
		else $error("reserved mode bits set");
	a_chop_tristate: assert property (@(posedge i_clk) disable iff (i_srst)
		(st_q == ST_BURST && in_chop_tail && ck_rise) |=> !o_dq_oe && !o_dqs_oe)
		else $error("drivers on in chop tail");
	// Order checks watch the registered columns; the beat count has already stepped
	a_wr8_order: assert property (@(posedge i_clk) disable iff (i_srst)
		(o_wr_en && len_q == BEATS_8) |-> o_wr_col[2:0] == 3'(beat_q - 4'h1))
		else $error("eight write order wrong");
	a_ilv_order: assert property (@(posedge i_clk) disable iff (i_srst)
		(o_rd_col_valid && !seq_q) |-> o_rd_col[2:0] == (3'(beat_q - 4'h1) ^ start_q))
		else $error("interleave order wrong");
	a_seq_nibble: assert property (@(posedge i_clk) disable iff (i_srst)
		(o_rd_col_valid && seq_q) |-> o_rd_col[2:0] ==
		{(beat_q > BEATS_4) ^ start_q[2], 2'(beat_q - 4'h1 + 4'(start_q[1:0]))})
		else $error("sequential nibble wrong");
	a_latency_range: assert property (@(posedge i_clk) disable iff (i_srst)
		cl_dec >= CL_MIN && cl_dec <= CL_MAX)
		else $error("read latency out of range");
	a_dll_powerdown: assert property (@(posedge i_clk) disable iff (i_srst)
		(i_power_down && !mode_q[PPD_BIT]) |-> !o_dll_run)
		else $error("dll running in slow power-down");
	a_otf_length: assert property (@(posedge i_clk) disable iff (i_srst)
		(st_q == ST_IDLE && cur_cmd == CMD_READ && mode_q[BL_LO+:2] == BL_OTF)
		|=> len_q == ($past(cur_addr[OTF_BIT]) ? BEATS_8 : BEATS_4))
		else $error("on-the-fly length wrong");
endmodule : smr_core

/* test/smr_ctrl_model.sv */
// Controller model: memory clock, command, address and write data pins.
// Assumes the block finds memory clock edges with its own faster clock.
`timescale 1ns/100ps
module smr_ctrl_model
	import smr_pkg::*;
(
	output logic o_mem_clk,
	output logic [2:0] o_cmd,
	output logic [MR_W-1:0] o_addr,
	output logic [DQ_W-1:0] o_wdata
);
	int rises;
	// Idle pins; the clock stands still between frames
	initial begin
		o_mem_clk = 1'b0;
		o_cmd = CMD_NOP;
		o_addr = '0;
		o_wdata = 8'h5a;
		rises = 0;
	end
	// One 125 ns period; pins change only while the clock is low
	task automatic tick(input logic [2:0] c, input logic [MR_W-1:0] a);
		#31;
		o_cmd = c;
		o_addr = (c == CMD_MODE_SET) ? (a & ~MR_RSVD_MASK) : a;
		o_wdata = o_wdata + 8'h11;
		#32;
		o_mem_clk = 1'b1;
		rises++;
		#62;
		o_mem_clk = 1'b0;
	endtask : tick
	// Command, then n idle periods so no burst is cut into
	task automatic frame(input logic [2:0] c, input logic [MR_W-1:0] a, input int n);
		tick(c, a);
		// Released address shows the inverse of its last value
		repeat (n) tick(CMD_NOP, ~o_addr);
	endtask : frame
endmodule : smr_ctrl_model

/* test/sdram_mode_reg0_burst_logic_tb.sv */
// Bench for the mode register zero burst logic: mode sets, bursts, FIFO.
// Assumes the controller model drives the command pins at 125 ns per period.
`timescale 1ns/100ps
module sdram_mode_reg0_burst_logic_tb;
	import smr_pkg::*;
	logic i_clk, i_srst, mem_clk, i_power_down, i_rd_valid, o_rd_ready, o_dq_oe, o_dqs_oe;
	logic o_wr_en, o_rd_col_valid, o_dll_reset, o_dll_run;
	logic [2:0] cmd;
	logic [MR_W-1:0] addr, o_mode, md;
	logic [DQ_W-1:0] wdata, i_rd_data, o_dq, o_wr_data;
	logic [COL_W-1:0] o_wr_col, o_rd_col;
	logic [3:0] o_write_recovery, o_read_latency;
	logic [COL_W-1:0] rq[$], wq[$];
	int failures, num_checks, first_rise, dll_pulses, n, popped;
	int wrt[7] = '{5, 5, 6, 7, 8, 10, 12};
	smr_ctrl_model m (.o_mem_clk(mem_clk), .o_cmd(cmd), .o_addr(addr), .o_wdata(wdata));
	smr_core dut (.i_clk(i_clk), .i_srst(i_srst), .i_mem_clk(mem_clk), .i_cmd(cmd),
		.i_addr(addr), .i_power_down(i_power_down), .i_wdata(wdata), .i_rd_valid(i_rd_valid),
		.o_rd_ready(o_rd_ready), .i_rd_data(i_rd_data), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
		.o_dqs_oe(o_dqs_oe), .o_wr_en(o_wr_en), .o_wr_col(o_wr_col), .o_wr_data(o_wr_data),
		.o_rd_col(o_rd_col), .o_rd_col_valid(o_rd_col_valid), .o_dll_reset(o_dll_reset),
		.o_dll_run(o_dll_run), .o_write_recovery(o_write_recovery),
		.o_read_latency(o_read_latency), .o_mode(o_mode));
	// Core clock, 100 MHz
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	// Beat monitor; first beat marks the memory clock rise it fell in
	always @(posedge i_clk) begin
		if (o_rd_col_valid === 1'b1) begin
			if (rq.size() == 0) first_rise = m.rises;
			rq.push_back(o_rd_col);
			chk(o_dq_oe === 1'b1 && o_dqs_oe === 1'b1, "drivers on in beat");
			// Words leave in fill order, then zero once the FIFO is empty
			chk(o_dq === (popped < FIFO_DEPTH ? 8'h40 + 8'(popped) : 8'h00), "rd data");
			popped++;
		end
		if (o_wr_en === 1'b1) begin
			wq.push_back(o_wr_col);
			chk(o_wr_data === wdata, "write data");
		end
		if (o_dll_reset === 1'b1) dll_pulses++;
	end
	task automatic chk(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1) begin
			failures++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : report_and_stop
	// Mode word: reserved bits left zero
	function automatic logic [MR_W-1:0] mv(input logic [1:0] bl, input logic bt,
		input logic [2:0] cl, input logic [2:0] wr, input logic ppd, input logic dll);
		return {6'h00, ppd, wr, dll, 1'b0, cl, bt, 1'b0, bl};
	endfunction : mv
	// Expected low column bits of beat i
	function automatic logic [2:0] ecol(input logic rd, input logic l8, input logic il,
		input logic [2:0] s, input int i);
		logic [2:0] b;
		b = 3'(i);
		if (!rd) return l8 ? b : {s[2], b[1:0]};
		if (il) return l8 ? (s ^ b) : {s[2], s[1:0] ^ b[1:0]};
		return {s[2] ^ (l8 & b[2]), s[1:0] + b[1:0]};
	endfunction : ecol
	task automatic mset(input logic [MR_W-1:0] a);
		m.frame(CMD_MODE_SET, a, 4);
		md = a & ~MR_RSVD_MASK;
		md[DLL_BIT] = 1'b0;
		chk(o_mode === md, "stored mode");
	endtask : mset
	// One burst; columns, and for reads the first-beat rise, checked against the mode
	task automatic burst(input logic [2:0] c, input logic [MR_W-1:0] a);
		logic l8;
		int r0;
		rq.delete();
		wq.delete();
		r0 = m.rises + 1;
		l8 = (md[1:0] == BL_FIXED8) || (md[1:0] == BL_OTF && a[12]);
		m.frame(c, a, 20);
		if (c == CMD_READ) begin
			chk(rq.size() == (l8 ? 8 : 4), "read beat count");
			chk(first_rise - r0 == int'(md[6:4]) + 4, "first read beat rise");
			foreach (rq[i]) chk(rq[i] === {a[9:3], ecol(1, l8, md[3], a[2:0], i)}, "rd col");
		end else begin
			chk(wq.size() == (l8 ? 8 : 4), "write beat count");
			foreach (wq[i]) chk(wq[i] === {a[9:3], ecol(0, l8, md[3], a[2:0], i)}, "wr col");
		end
		chk(o_dq_oe === 1'b0 && o_dqs_oe === 1'b0, "drivers off after burst");
	endtask : burst
	initial begin
		#300us;
		failures++;
		report_and_stop();
	end
	initial begin
		i_srst = 1'b1;
		i_power_down = 1'b0;
		i_rd_valid = 1'b0;
		i_rd_data = 8'h00;
		failures = 0;
		num_checks = 0;
		dll_pulses = 0;
		first_rise = 0;
		popped = 0;
		repeat (3) @(posedge i_clk);
		#1 i_srst = 1'b0;
		repeat (4) @(posedge i_clk);
		// Model pins then move away from core clock edges
		#1;
		chk(o_mode === 19'h00000 && o_read_latency === 4'h5, "reset mode");
		chk(o_write_recovery === 4'h5 && o_dll_run === 1'b1, "reset decode");
		// Latency and recovery codes 1 to 6; recovery chosen rounded up
		for (int k = 1; k <= 6; k++) begin
			mset(mv(BL_FIXED8, 1'b0, 3'(k), 3'(k), 1'b0, 1'b0));
			chk(o_read_latency === 4'(k + 4), "latency decode");
			chk(o_write_recovery === 4'(wrt[k]), "recovery decode");
		end
		mset(mv(BL_FIXED8, 1'b0, 3'h1, 3'h1, 1'b0, 1'b1));
		chk(dll_pulses == 1, "one dll reset pulse");
		m.frame(CMD_NOP, 19'h00000, 512);
		// Power-down with the DLL stopping, then kept running
		for (int p = 0; p < 2; p++) begin
			mset(mv(BL_FIXED8, 1'b0, 3'h1, 3'h1, 1'(p), 1'b0));
			@(posedge i_clk);
			#1 i_power_down = 1'b1;
			repeat (2) @(posedge i_clk);
			chk(o_dll_run === 1'(p), "dll in power-down");
			#1 i_power_down = 1'b0;
			repeat (2) @(posedge i_clk);
			chk(o_dll_run === 1'b1, "dll outside power-down");
			#1;
			m.frame(CMD_NOP, 19'h00000, 4);
		end
		// Fill the read FIFO until it refuses
		n = 0;
		repeat (20) begin
			@(posedge i_clk);
			#1 i_rd_valid = o_rd_ready;
			i_rd_data = 8'h40 + 8'(n);
			if (o_rd_ready === 1'b1) n++;
		end
		@(posedge i_clk);
		#1 i_rd_valid = 1'b0;
		chk(n == FIFO_DEPTH, "fifo fill count");
		mset(mv(BL_FIXED8, 1'b0, 3'h1, 3'h1, 1'b0, 1'b0));
		burst(CMD_READ, 19'h000f9);
		chk(o_rd_ready === 1'b1, "fifo drained by read");
		mset(mv(BL_FIXED8, 1'b1, 3'h2, 3'h1, 1'b0, 1'b0));
		burst(CMD_READ, 19'h0023f);
		burst(CMD_WRITE, 19'h00133);
		mset(mv(BL_CHOP4, 1'b0, 3'h3, 3'h1, 1'b0, 1'b0));
		burst(CMD_READ, 19'h000ae);
		burst(CMD_WRITE, 19'h00065);
		mset(mv(BL_OTF, 1'b1, 3'h1, 3'h1, 1'b0, 1'b0));
		burst(CMD_READ, 19'h00015);
		burst(CMD_READ, 19'h01015);
		report_and_stop();
	end
endmodule : sdram_mode_reg0_burst_logic_tb
